// ==== hw/daq_path_pkg.sv ====
// shared constants and carrier types of the acquisition data-path selector
// assumes one system clock; sample ticks come from the frequency selector
`default_nettype none
package daq_path_pkg;

  localparam int unsigned ADC_W = 12;
  localparam int unsigned LANE_W = 16;
  localparam int unsigned PAD_W = LANE_W - ADC_W;
  localparam int unsigned PAIR_W = 2;
  localparam int unsigned SYNC_W = 2 * ADC_W + 2 * LANE_W;

  // stream select encodings
  localparam logic SEL_CONV = 1'b0;
  localparam logic SEL_EXT = 1'b1;

  // reset values
  localparam logic [PAIR_W-1:0] PAIR_RST = 2'h0;
  localparam logic [ADC_W-1:0] CODE_RST = 12'h000;
  localparam logic [LANE_W-1:0] LANE_RST = 16'h0000;
  localparam logic [PAD_W-1:0] PAD_ZERO = 4'h0;

  // two converter samples taken at one instant
  typedef struct packed {
    logic [ADC_W-1:0] chTwo;
    logic [ADC_W-1:0] chOne;
  } convPair_t;

  // two 16-bit lanes, lane two in the upper half
  typedef struct packed {
    logic [LANE_W-1:0] laneTwo;
    logic [LANE_W-1:0] laneOne;
  } lanePair_t;

  // selection fields of the mux configuration register
  typedef struct packed {
    logic [PAIR_W-1:0] pairSel;
    logic inStreamSel;
    logic outStreamSel;
  } muxCfg_t;

  localparam muxCfg_t CFG_RST = '{pairSel: PAIR_RST, inStreamSel: SEL_CONV,
                                  outStreamSel: SEL_CONV};

endpackage : daq_path_pkg
`default_nettype wire

// ==== hw/sync_two_flop.sv ====
// two-stage synchroniser for a bus of pin inputs
// assumes each bit is sampled only as a static or slowly varying level
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // both stages clear together so no stale pin level survives reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule // sync_two_flop
`default_nettype wire

// ==== hw/daq_stream_path_select.sv ====
// data-path selector: analog pair steering, input and output stream muxes
// assumes config inputs and sample tick come from logic on clk_sys, while
// converter and external input data arrive on pins
`timescale 1ns/1ps
`default_nettype none
module daq_stream_path_select #(
  parameter int unsigned ADC_WIDTH = daq_path_pkg::ADC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire daq_path_pkg::muxCfg_t cfgIn,
  input wire logic sampleTick,
  input wire logic inAcqEn,
  input wire logic outAcqEn,
  input wire daq_path_pkg::convPair_t convIn,
  input wire daq_path_pkg::lanePair_t extInStream,
  input wire daq_path_pkg::lanePair_t outFifoData,
  input wire logic outFifoValid,
  output logic [daq_path_pkg::PAIR_W-1:0] analogPairSel,
  output daq_path_pkg::lanePair_t inLanes,
  output logic inFifoWrEn,
  output logic extInClk,
  output logic extInEn,
  output logic outFifoRdEn,
  output logic [daq_path_pkg::ADC_W-1:0] dacOneCode,
  output logic [daq_path_pkg::ADC_W-1:0] dacTwoCode,
  output logic dacUpdate,
  output daq_path_pkg::lanePair_t extOutStream,
  output logic extOutClk,
  output logic extOutEn
);

  // converter sample zero-extended into a 16-bit lane
  function automatic logic [daq_path_pkg::LANE_W-1:0] padSample(
    input logic [daq_path_pkg::ADC_W-1:0] s);
    padSample = {daq_path_pkg::PAD_ZERO, s};
  endfunction

  // pin synchronisation for converter and external input data
  logic [daq_path_pkg::SYNC_W-1:0] pinRaw;
  logic [daq_path_pkg::SYNC_W-1:0] pinSync;
  daq_path_pkg::convPair_t convSync;
  daq_path_pkg::lanePair_t extSync;

  assign pinRaw = {convIn, extInStream};

  sync_two_flop #(
    .WIDTH(daq_path_pkg::SYNC_W)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .asyncIn(pinRaw),
    .syncOut(pinSync)
  );

  // split the synchronised word back into its two sources
  assign convSync = pinSync[daq_path_pkg::SYNC_W-1:2*daq_path_pkg::LANE_W];
  assign extSync = pinSync[2*daq_path_pkg::LANE_W-1:0];

  // configuration group
  daq_path_pkg::muxCfg_t cfg_q;
  daq_path_pkg::muxCfg_t cfg_d;
  logic [daq_path_pkg::PAIR_W-1:0] pairSel_q;
  logic [daq_path_pkg::PAIR_W-1:0] pairSel_d;

  // selections are only taken at a tick, so no word sees a half switch
  always_comb begin
    cfg_d = cfg_q;
    pairSel_d = pairSel_q;
    if (sampleTick) begin
      cfg_d = cfgIn;
      pairSel_d = cfgIn.pairSel;
    end
  end

  // selection registers, cleared to pair 0 and converter routes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q <= daq_path_pkg::CFG_RST;
      pairSel_q <= daq_path_pkg::PAIR_RST;
    end else begin
      cfg_q <= cfg_d;
      pairSel_q <= pairSel_d;
    end
  end

  // one field drives both channels' analog selectors
  assign analogPairSel = pairSel_q;

  // input stream group
  daq_path_pkg::lanePair_t inLanes_q;
  daq_path_pkg::lanePair_t inLanes_d;
  logic inWr_q;
  logic inWr_d;
  logic extInClk_q;
  logic extInClk_d;
  logic extInEn_q;
  logic extInEn_d;
  logic inTake;

  // both converter channels and both external halves taken on one edge
  assign inTake = sampleTick & inAcqEn;

  // next lane word, write strobe and external sync outputs
  always_comb begin
    inLanes_d = inLanes_q;
    inWr_d = 1'b0;
    extInEn_d = inAcqEn;
    extInClk_d = inTake; // high one cycle per sample; back-to-back samples merge into one longer pulse
    if (inTake) begin
      inWr_d = 1'b1;
      if (cfg_q.inStreamSel == daq_path_pkg::SEL_CONV) begin
        inLanes_d.laneOne = padSample(convSync.chOne);
        inLanes_d.laneTwo = padSample(convSync.chTwo);
      end else begin
        inLanes_d = extSync;
      end
    end
  end

  // input path registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inLanes_q <= '{laneTwo: daq_path_pkg::LANE_RST,
                     laneOne: daq_path_pkg::LANE_RST};
      inWr_q <= 1'b0;
      extInClk_q <= 1'b0;
      extInEn_q <= 1'b0;
    end else begin
      inLanes_q <= inLanes_d;
      inWr_q <= inWr_d;
      extInClk_q <= extInClk_d;
      extInEn_q <= extInEn_d;
    end
  end

  // lane one to first FIFO, lane two to second, one common strobe
  assign inLanes = inLanes_q;
  assign inFifoWrEn = inWr_q;
  assign extInClk = extInClk_q;
  assign extInEn = extInEn_q;

  // output stream group
  logic [daq_path_pkg::ADC_W-1:0] dacOne_q;
  logic [daq_path_pkg::ADC_W-1:0] dacOne_d;
  logic [daq_path_pkg::ADC_W-1:0] dacTwo_q;
  logic [daq_path_pkg::ADC_W-1:0] dacTwo_d;
  logic dacUpd_q;
  logic dacUpd_d;
  daq_path_pkg::lanePair_t extOut_q;
  daq_path_pkg::lanePair_t extOut_d;
  logic extOutClk_q;
  logic extOutClk_d;
  logic extOutEn_q;
  logic extOutEn_d;
  logic outRd_q;
  logic outRd_d;
  logic outTake;

  // output FIFO shows its head word; a tick with data pops it
  // a pop still in flight blocks a second take of the same head word
  assign outTake = sampleTick & outAcqEn & outFifoValid & !outRd_q;

  // next converter codes or external word, with their strobes
  always_comb begin
    dacOne_d = dacOne_q;
    dacTwo_d = dacTwo_q;
    dacUpd_d = 1'b0;
    extOut_d = extOut_q;
    extOutClk_d = 1'b0;
    outRd_d = outTake;
    extOutEn_d = outAcqEn &
                 (cfg_q.outStreamSel == daq_path_pkg::SEL_EXT);
    if (outTake) begin
      if (cfg_q.outStreamSel == daq_path_pkg::SEL_CONV) begin
        // both codes load on the same edge
        dacOne_d = outFifoData.laneOne[daq_path_pkg::ADC_W-1:0];
        dacTwo_d = outFifoData.laneTwo[daq_path_pkg::ADC_W-1:0];
        dacUpd_d = 1'b1;
      end else begin
        extOut_d = outFifoData;
        extOutClk_d = 1'b1;
      end
    end
  end

  // output path registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dacOne_q <= daq_path_pkg::CODE_RST;
      dacTwo_q <= daq_path_pkg::CODE_RST;
      dacUpd_q <= 1'b0;
      extOut_q <= '{laneTwo: daq_path_pkg::LANE_RST,
                    laneOne: daq_path_pkg::LANE_RST};
      extOutClk_q <= 1'b0;
      extOutEn_q <= 1'b0;
      outRd_q <= 1'b0;
    end else begin
      dacOne_q <= dacOne_d;
      dacTwo_q <= dacTwo_d;
      dacUpd_q <= dacUpd_d;
      extOut_q <= extOut_d;
      extOutClk_q <= extOutClk_d;
      extOutEn_q <= extOutEn_d;
      outRd_q <= outRd_d;
    end
  end

  // every output leaves straight from its register
  assign dacOneCode = dacOne_q;
  assign dacTwoCode = dacTwo_q;
  assign dacUpdate = dacUpd_q;
  assign extOutStream = extOut_q;
  assign extOutClk = extOutClk_q;
  assign extOutEn = extOutEn_q;
  assign outFifoRdEn = outRd_q;

  // assertions on the selection and stream paths
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pair_follows_tick_a: assert property (
    sampleTick |=> analogPairSel == $past(cfgIn.pairSel))
    else $error("analog pair select did not follow tick");

  pair_copy_a: assert property (
    analogPairSel == cfg_q.pairSel)
    else $error("analog pair select differs from latched field");

  cfg_held_between_a: assert property (
    !sampleTick |=> $stable(cfg_q) && $stable(analogPairSel))
    else $error("selection changed away from a tick");

  write_on_take_a: assert property (
    inFifoWrEn == $past(inTake))
    else $error("input FIFO write not one cycle after sample");

  conv_lane_pad_a: assert property (
    inTake && cfg_q.inStreamSel == daq_path_pkg::SEL_CONV |=>
      inLanes.laneOne == padSample($past(convSync.chOne)) &&
      inLanes.laneTwo == padSample($past(convSync.chTwo)))
    else $error("converter sample not zero-extended into lanes");

  ext_lane_split_a: assert property (
    inTake && cfg_q.inStreamSel == daq_path_pkg::SEL_EXT |=>
      inLanes.laneOne == $past(extSync.laneOne) &&
      inLanes.laneTwo == $past(extSync.laneTwo))
    else $error("external halves not placed in lanes");

  ext_sync_outs_a: assert property (
    inTake |=> extInClk && extInEn)
    else $error("external clock or enable wrong after sample");

  ext_clk_pulse_a: assert property (
    !inTake |=> !extInClk)
    else $error("external clock pulsed without a sample");

  in_en_follow_a: assert property (
    $past(rst_n) |-> extInEn == $past(inAcqEn))
    else $error("external enable did not follow acquisition enable");

  dac_codes_hold_a: assert property (
    !dacUpdate |-> $stable(dacOneCode) && $stable(dacTwoCode))
    else $error("converter code moved without common update");

  dac_route_a: assert property (
    outTake && cfg_q.outStreamSel == daq_path_pkg::SEL_CONV |=>
      dacUpdate && outFifoRdEn && !extOutClk &&
      dacOneCode == $past(outFifoData.laneOne[daq_path_pkg::ADC_W-1:0]) &&
      $stable(extOutStream))
    else $error("output lanes not routed to converters");

  dac_two_route_a: assert property (
    outTake && cfg_q.outStreamSel == daq_path_pkg::SEL_CONV |=>
      dacTwoCode == $past(outFifoData.laneTwo[daq_path_pkg::ADC_W-1:0]))
    else $error("second converter code not from lane two");

  ext_out_route_a: assert property (
    outTake && cfg_q.outStreamSel == daq_path_pkg::SEL_EXT |=>
      extOutClk && !dacUpdate && extOutStream == $past(outFifoData))
    else $error("output lanes not routed to external stream");

  out_en_follow_a: assert property (
    $past(rst_n) |-> extOutEn ==
      $past(outAcqEn && cfg_q.outStreamSel == daq_path_pkg::SEL_EXT))
    else $error("external output enable did not follow its route");

  empty_no_pop_a: assert property (
    outFifoRdEn |-> $past(outFifoValid) && $past(outAcqEn))
    else $error("output FIFO popped while empty or idle");

  common_tick_a: assert property (
    (inFifoWrEn || outFifoRdEn) |-> $past(sampleTick))
    else $error("data moved without the common sampling tick");

  reset_quiet_a: assert property (
    !$past(rst_n) |-> !inFifoWrEn && !outFifoRdEn && !extInClk &&
      !extOutClk && !dacUpdate)
    else $error("strobe active right after reset");

endmodule // daq_stream_path_select
`default_nettype wire

// ==== dv/fifo_feed_model.sv ====
// output fifo model: first-word-fall-through head for both output lanes
// assumes the bench pushes words and the design pops with rdEn
`timescale 1ns/1ps
`default_nettype none
module fifo_feed_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pushEn,
  input wire daq_path_pkg::lanePair_t pushData,
  input wire logic rdEn,
  output daq_path_pkg::lanePair_t data,
  output logic valid
);
  daq_path_pkg::lanePair_t q[$];
  daq_path_pkg::lanePair_t last = '0;
  // head advances at the edge that sees the pop; empty shows no stale word
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      q.delete();
    end else begin
      if (rdEn && q.size() > 0) last = q.pop_front();
      if (pushEn) q.push_back(pushData);
    end
    valid <= q.size() > 0;
    data <= (q.size() > 0) ? q[0] : ~last;
  end
endmodule // fifo_feed_model
`default_nettype wire

// ==== dv/test_daq_stream_path_select.sv ====
// self-checking bench of the acquisition data-path selector
// assumes the design package and the output fifo model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_daq_stream_path_select;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sampleTick = 1'b0, inAcqEn = 1'b0, outAcqEn = 1'b0, pushEn = 1'b0;
  daq_path_pkg::muxCfg_t cfgIn = daq_path_pkg::CFG_RST, cfg;
  daq_path_pkg::convPair_t convIn = '0;
  daq_path_pkg::lanePair_t extInStream = '0, pushData = '0, outFifoData;
  daq_path_pkg::lanePair_t inLanes, extOutStream, ew, pw, w2, inExp;
  logic [daq_path_pkg::PAIR_W-1:0] analogPairSel;
  logic [daq_path_pkg::ADC_W-1:0] dacOneCode, dacTwoCode;
  logic outFifoValid, inFifoWrEn, extInClk, extInEn, outFifoRdEn;
  logic dacUpdate, extOutClk, extOutEn, prevIn = 1'b0, prevOut = 1'b0;
  logic [23:0] cv;
  logic [32:0] o;
  int badCount = 0, cmpCount = 0, seed = 61;
  daq_path_pkg::lanePair_t inQ[$];
  logic [32:0] outQ[$];

  always #4 clk_sys = ~clk_sys;

  daq_stream_path_select dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cfgIn(cfgIn), .sampleTick(sampleTick), .inAcqEn(inAcqEn),
    .outAcqEn(outAcqEn), .convIn(convIn), .extInStream(extInStream),
    .outFifoData(outFifoData), .outFifoValid(outFifoValid),
    .analogPairSel(analogPairSel), .inLanes(inLanes),
    .inFifoWrEn(inFifoWrEn), .extInClk(extInClk), .extInEn(extInEn),
    .outFifoRdEn(outFifoRdEn), .dacOneCode(dacOneCode),
    .dacTwoCode(dacTwoCode), .dacUpdate(dacUpdate),
    .extOutStream(extOutStream), .extOutClk(extOutClk),
    .extOutEn(extOutEn));

  fifo_feed_model feed (.clk_sys(clk_sys), .rst_n(rst_n), .pushEn(pushEn),
    .pushData(pushData), .rdEn(outFifoRdEn), .data(outFifoData),
    .valid(outFifoValid));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    cmpCount++;
    if (e !== s) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic endOfTest;
    if (badCount == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // raise the tick for n back-to-back edges
  task automatic tick(input int n);
    @(posedge clk_sys) sampleTick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    sampleTick <= 1'b0;
  endtask

  // monitor: pops the oldest note whenever a result strobe appears
  always @(posedge clk_sys) begin
    if (rst_n) begin
      chk("extInEn", 32'(prevIn), 32'(extInEn));
      chk("extInClk", 32'(inFifoWrEn), 32'(extInClk));
      chk("extOutEn", 32'(prevOut), 32'(extOutEn));
      if (inFifoWrEn === 1'b1) begin
        inExp = (inQ.size() > 0) ? inQ.pop_front() : ~inLanes;
        chk("inLanes", inExp, inLanes);
      end
      if (outFifoRdEn === 1'b1) begin
        o = (outQ.size() > 0) ? outQ.pop_front() : {1'b1, ~extOutStream};
        if (o[32]) begin
          chk("extOutClk", 32'h1, 32'(extOutClk));
          chk("extOutStream", o[31:0], extOutStream);
        end else begin
          chk("dacUpdate", 32'h1, 32'(dacUpdate));
          chk("dacCodes", {8'h0, o[27:16], o[11:0]},
              {8'h0, dacTwoCode, dacOneCode});
        end
      end else begin
        chk("outIdle", 32'h0, 32'({dacUpdate, extOutClk}));
      end
    end
    prevIn <= inAcqEn;
    // outAcqEn is only raised while cfg is the latched selection
    prevOut <= outAcqEn & cfg.outStreamSel;
  end

  // main sequence: every pair and both selects, each way
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      cfg = '{pairSel: i[1:0], inStreamSel: i[2], outStreamSel: i[0]};
      cfgIn <= cfg;
      tick(1);
      cfgIn <= 4'($random(seed));
      repeat (3) @(posedge clk_sys);
      chk("analogPairSel", 32'(cfg.pairSel),
          32'(analogPairSel));
      cv = 24'($random(seed));
      ew = $random(seed);
      pw = $random(seed);
      cfgIn <= cfg;
      convIn <= cv;
      extInStream <= ew;
      pushData <= pw;
      pushEn <= 1'b1;
      @(posedge clk_sys) pushEn <= 1'b0;
      inAcqEn <= 1'b1;
      // converter words sit zero-padded in the low lane bits
      w2 = {4'h0, cv[23:12], 4'h0, cv[11:0]};
      if (cfg.inStreamSel) w2 = ew;
      inQ.push_back(w2);
      inQ.push_back(w2);
      tick(2); // back-to-back ticks keep the converter rate high
      @(posedge clk_sys) inAcqEn <= 1'b0;
      outAcqEn <= 1'b1;
      outQ.push_back({cfg.outStreamSel, pw});
      tick(1);
      tick(1);
      @(posedge clk_sys) outAcqEn <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (5) @(posedge clk_sys);
    chk("inQ left", 32'h0, 32'(inQ.size()));
    chk("outQ left", 32'h0, 32'(outQ.size()));
    endOfTest();
  end

  // watchdog against a hang
  initial begin
    #40000;
    badCount++;
    endOfTest();
  end
endmodule // test_daq_stream_path_select
`default_nettype wire
